// [design/rkmi_top.sv]
// RTC key protection, day rollover, pin functions and pending interrupt
//
// Contract
// - Calibration enable drives selected frequency on pin
// - Select codes give 1, 512, 500, 16384 Hz
// - Decode external interrupt pin function fields
// - Power control write needs power key first
// - Counter and pin config writes need timekeeping key first
// - Counters advance on 32.768 kHz time base
// - Config and interval take effect at 128 Hz
// - Counters keep running while read; software rereads
// - Hours roll at 23 or 255 by mode
// - Day rollover sets flag and pends interrupt
// - Day event wakes core from deep sleep
// - Day and alarm share one gated interrupt
// - Vectoring clears pending; disabled stays pending
// - Flags stay set until software clears them
// - Keep waking until pending interrupt serviced
// - Hundredths wrap 127 to 0, carry seconds
// - Seconds and minutes wrap at 59, carry
// - Counters clear only on power-on reset
`timescale 1ns/1ps
module rkmi_top #(
  parameter int MCLK_HZ     = rkmi_pkg::MCLK_HZ_DEFAULT,
  parameter int HALF_500HZ  = MCLK_HZ / (2 * rkmi_pkg::CAL_500_HZ)
) (
  // Clock and resets
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               porReset_n,
  // Special function register port
  input  wire rkmi_pkg::rkmi_sfr_s sfrReq,
  output logic [7:0]              sfrRdData_q,
  // Core interrupt and power handshake
  input  wire logic               alarmEvent,
  input  wire logic               irqVectored,
  input  wire logic               deepSleepPowerMode,
  output logic                    rtcIrqReq_q,
  output logic                    wakeReq_q,
  // Calibration output pin
  output logic                    calOutputPin_q,
  output logic                    calOutputPinOe_n_q,
  // External interrupt pin functions
  output logic                    extIrq1GpioSel_q,
  output logic                    extIrq1BattCtrlSel_q,
  output logic                    extIrq1Enable_q,
  output logic                    extIrq0Enable_q,
  // Registers seen by other logic
  output logic [7:0]              powerControlReg_q,
  output logic [7:0]              alarmIntervalEff_q
);
  import rkmi_pkg::*;

  localparam int ACC_W = 28;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(RTC_CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(MCLK_HZ);

  if (MCLK_HZ < 4 * RTC_CLK_HZ || MCLK_HZ > 100_000_000) begin : g_chk
    $error("MCLK_HZ out of supported range");
  end

  // ==========================================================================
  // Helpers
  function automatic logic isCounterAddr(input logic [7:0] a);
    return (a >= ADDR_HUNDREDTH) && (a <= ADDR_HOURS);
  endfunction

  function automatic logic [7:0] wrapInc(input logic [7:0] v,
                                         input logic [7:0] lim);
    return (v == lim) ? 8'h00 : 8'(v + 8'h01);
  endfunction

  // ==========================================================================
  // Time base
  logic [ACC_W-1:0] phaseAcc_q;
  logic             tick32_q;
  logic [7:0]       subCnt_q;
  logic             tick128;

  // Fractional divider; edges jitter by one mclk but average exactly
  always_ff @(posedge mclk or negedge porReset_n) begin
    if (!porReset_n) begin
      phaseAcc_q <= '0;
      tick32_q   <= 1'b0;
    end else if (phaseAcc_q + ACC_STEP >= ACC_MOD) begin
      phaseAcc_q <= phaseAcc_q + ACC_STEP - ACC_MOD;
      tick32_q   <= 1'b1;
    end else begin
      phaseAcc_q <= phaseAcc_q + ACC_STEP;
      tick32_q   <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge porReset_n) begin
    if (!porReset_n) begin
      subCnt_q <= 8'h00;
    end else if (tick32_q) begin
      subCnt_q <= 8'(subCnt_q + 8'h01);
    end
  end

  assign tick128 = tick32_q && (subCnt_q == SUB_LAST);

  // ==========================================================================
  // Key and write acceptance
  logic [7:0]   writeUnlockKey_q;
  rkmi_pincfg_s pinFunctionConfig_q;
  logic         cntWrOk;
  logic         pinWrOk;
  logic         powWrOk;
  logic         keyWr;
  logic [1:0]   cntIdx;

  assign keyWr   = sfrReq.wr && (sfrReq.addr == ADDR_KEY);
  assign cntWrOk = sfrReq.wr && isCounterAddr(sfrReq.addr)
                   && (writeUnlockKey_q == KEY_RTC);
  assign pinWrOk = sfrReq.wr && (sfrReq.addr == ADDR_PINCFG)
                   && (writeUnlockKey_q == KEY_RTC);
  assign powWrOk = sfrReq.wr && (sfrReq.addr == ADDR_POWER)
                   && (writeUnlockKey_q == KEY_POWER);
  assign cntIdx  = 2'(sfrReq.addr - ADDR_HUNDREDTH);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      writeUnlockKey_q <= KEY_LOCKED;
    end else if (keyWr) begin
      writeUnlockKey_q <= sfrReq.data;
    end else if (cntWrOk || pinWrOk || powWrOk) begin
      writeUnlockKey_q <= KEY_LOCKED;
    end
  end

  // Reserved bit is stored as written; software must keep it zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinFunctionConfig_q <= rkmi_pincfg_s'(RESET_BYTE);
    end else if (pinWrOk) begin
      pinFunctionConfig_q <= rkmi_pincfg_s'(sfrReq.data);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      powerControlReg_q <= RESET_BYTE;
    end else if (powWrOk) begin
      powerControlReg_q <= sfrReq.data;
    end
  end

  // ==========================================================================
  // Configuration, shadow and 128 Hz effective copies
  logic [7:0] rtcConfigReg_q;
  logic [7:0] alarmIntervalReg_q;
  logic [7:0] rtcConfigEff_q;
  logic [7:0] irqEnablePriority2Reg_q;
  logic       dayFlag_q;
  logic       alarmFlag_q;
  logic       cfgWr;

  assign cfgWr = sfrReq.wr && (sfrReq.addr == ADDR_CONFIG);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rtcConfigReg_q          <= RESET_BYTE;
      alarmIntervalReg_q      <= RESET_BYTE;
      irqEnablePriority2Reg_q <= RESET_BYTE;
    end else begin
      if (cfgWr) begin
        rtcConfigReg_q <= sfrReq.data;
      end
      if (sfrReq.wr && sfrReq.addr == ADDR_INTERVAL) begin
        alarmIntervalReg_q <= sfrReq.data;
      end
      if (sfrReq.wr && sfrReq.addr == ADDR_IRQ_PRIO2) begin
        irqEnablePriority2Reg_q <= sfrReq.data;
      end
    end
  end

  // The time base only samples its settings at the 128 Hz edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rtcConfigEff_q     <= RESET_BYTE;
      alarmIntervalEff_q <= RESET_BYTE;
    end else if (tick128) begin
      rtcConfigEff_q     <= rtcConfigReg_q;
      alarmIntervalEff_q <= alarmIntervalReg_q;
    end
  end

  // ==========================================================================
  // Timekeeping counters
  logic [7:0] cnt_q     [NUM_COUNTERS];
  logic [7:0] pendVal_q [NUM_COUNTERS];
  logic       pendFlag_q[NUM_COUNTERS];
  logic [7:0] cntLim    [NUM_COUNTERS];
  logic       carry     [NUM_COUNTERS+1];
  logic       dayRoll;
  logic       dayEvent_q;

  always_comb begin
    cntLim[0] = HUND_MAX;
    cntLim[1] = SEC_MAX;
    cntLim[2] = MIN_MAX;
    cntLim[3] = rtcConfigEff_q[CFG_DAY_LENGTH_BIT] ? HOUR24_MAX
                                                   : HOUR256_MAX;
    carry[0] = tick128;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      carry[i+1] = carry[i] && !pendFlag_q[i] && (cnt_q[i] == cntLim[i]);
    end
    dayRoll = carry[NUM_COUNTERS];
  end

  // Writes park in a holding stage and land on a time tick in one step
  always_ff @(posedge mclk or negedge porReset_n) begin
    if (!porReset_n) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        cnt_q[i]      <= RESET_BYTE;
        pendVal_q[i]  <= RESET_BYTE;
        pendFlag_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (cntWrOk && cntIdx == 2'(i)) begin
          pendVal_q[i]  <= sfrReq.data;
          pendFlag_q[i] <= 1'b1;
        end else if (tick32_q) begin
          pendFlag_q[i] <= 1'b0;
        end
        if (tick32_q && pendFlag_q[i]) begin
          cnt_q[i] <= pendVal_q[i];
        end else if (carry[i]) begin
          cnt_q[i] <= wrapInc(cnt_q[i], cntLim[i]);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dayEvent_q <= 1'b0;
    end else begin
      dayEvent_q <= dayRoll;
    end
  end

  // ==========================================================================
  // Event flags and pending interrupt
  logic rtcIrqPending_q;
  logic rtcIrqEnable;
  logic vectorTaken;

  assign rtcIrqEnable = irqEnablePriority2Reg_q[PRIO2_RTC_IRQ_BIT];
  assign vectorTaken  = irqVectored && rtcIrqEnable;

  // Setting wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dayFlag_q   <= 1'b0;
      alarmFlag_q <= 1'b0;
    end else begin
      if (dayEvent_q) begin
        dayFlag_q <= 1'b1;
      end else if (cfgWr && !sfrReq.data[CFG_DAY_FLAG_BIT]) begin
        dayFlag_q <= 1'b0;
      end
      if (alarmEvent) begin
        alarmFlag_q <= 1'b1;
      end else if (cfgWr && !sfrReq.data[CFG_ALARM_FLAG_BIT]) begin
        alarmFlag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rtcIrqPending_q <= 1'b0;
    end else if (dayEvent_q || alarmEvent) begin
      rtcIrqPending_q <= 1'b1;
    end else if (vectorTaken) begin
      rtcIrqPending_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rtcIrqReq_q <= 1'b0;
      wakeReq_q   <= 1'b0;
    end else begin
      rtcIrqReq_q <= rtcIrqPending_q && rtcIrqEnable;
      wakeReq_q   <= rtcIrqPending_q && deepSleepPowerMode;
    end
  end

  // ==========================================================================
  // Pin functions
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extIrq1GpioSel_q     <= 1'b0;
      extIrq1BattCtrlSel_q <= 1'b0;
      extIrq1Enable_q      <= 1'b0;
      extIrq0Enable_q      <= 1'b0;
      calOutputPinOe_n_q   <= 1'b1;
    end else begin
      extIrq1GpioSel_q <=
        pinFunctionConfig_q.extIrq1PinFunction[1:0] == 2'h0;
      extIrq1BattCtrlSel_q <=
        pinFunctionConfig_q.extIrq1PinFunction[1:0] == 2'h1;
      extIrq1Enable_q <=
        pinFunctionConfig_q.extIrq1PinFunction[2:1] == 2'h3;
      extIrq0Enable_q    <= pinFunctionConfig_q.extIrq0PinEnable;
      calOutputPinOe_n_q <= !pinFunctionConfig_q.calEnable;
    end
  end

  rkmi_cal_out #(
    .HALF_500HZ (HALF_500HZ)
  ) u_cal (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .tick32   (tick32_q),
    .enable   (pinFunctionConfig_q.calEnable),
    .sel      (rkmi_calsel_e'(pinFunctionConfig_q.calFreqSelect)),
    .calOut_q (calOutputPin_q)
  );

  // ==========================================================================
  // Read port; reads never stall or freeze the counters
  logic [7:0] cfgRead;

  always_comb begin
    cfgRead                     = rtcConfigReg_q;
    cfgRead[CFG_DAY_FLAG_BIT]   = dayFlag_q;
    cfgRead[CFG_ALARM_FLAG_BIT] = alarmFlag_q;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData_q <= RESET_BYTE;
    end else if (sfrReq.rd) begin
      case (sfrReq.addr)
        ADDR_CONFIG:    sfrRdData_q <= cfgRead;
        ADDR_HUNDREDTH: sfrRdData_q <= cnt_q[0];
        ADDR_SECONDS:   sfrRdData_q <= cnt_q[1];
        ADDR_MINUTES:   sfrRdData_q <= cnt_q[2];
        ADDR_HOURS:     sfrRdData_q <= cnt_q[3];
        ADDR_INTERVAL:  sfrRdData_q <= alarmIntervalReg_q;
        ADDR_IRQ_PRIO2: sfrRdData_q <= irqEnablePriority2Reg_q;
        ADDR_KEY:       sfrRdData_q <= writeUnlockKey_q;
        ADDR_POWER:     sfrRdData_q <= powerControlReg_q;
        ADDR_PINCFG:    sfrRdData_q <= pinFunctionConfig_q;
        default:        sfrRdData_q <= RESET_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  property p_power_locked;
    @(posedge mclk) disable iff (!reset_n)
    sfrReq.wr && sfrReq.addr == ADDR_POWER && writeUnlockKey_q != KEY_POWER
      |=> $stable(powerControlReg_q);
  endproperty
  a_power_locked: assert property (p_power_locked)
    else $error("power control written without key");

  property p_pincfg_locked;
    @(posedge mclk) disable iff (!reset_n)
    sfrReq.wr && sfrReq.addr == ADDR_PINCFG && writeUnlockKey_q != KEY_RTC
      |=> $stable(pinFunctionConfig_q);
  endproperty
  a_pincfg_locked: assert property (p_pincfg_locked)
    else $error("pin config written without key");

  property p_relock;
    @(posedge mclk) disable iff (!reset_n)
    (cntWrOk || pinWrOk || powWrOk) && !keyWr |=>
      writeUnlockKey_q == KEY_LOCKED;
  endproperty
  a_relock: assert property (p_relock)
    else $error("key not cleared after protected write");

  property p_day_flag;
    @(posedge mclk) disable iff (!reset_n)
    dayRoll |=> ##1 dayFlag_q && rtcIrqPending_q;
  endproperty
  a_day_flag: assert property (p_day_flag)
    else $error("day rollover did not set flag and pending");

  property p_irq_gate;
    @(posedge mclk) disable iff (!reset_n)
    rtcIrqReq_q |-> $past(rtcIrqPending_q) && $past(rtcIrqEnable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request without enable");

  property p_hold_pending;
    @(posedge mclk) disable iff (!reset_n)
    rtcIrqPending_q && !rtcIrqEnable |=> rtcIrqPending_q;
  endproperty
  a_hold_pending: assert property (p_hold_pending)
    else $error("disabled pending interrupt was lost");

  property p_vector_clear;
    @(posedge mclk) disable iff (!reset_n)
    vectorTaken && !dayEvent_q && !alarmEvent |=> !rtcIrqPending_q;
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("vectoring did not clear pending");

  property p_wake;
    @(posedge mclk) disable iff (!reset_n)
    dayEvent_q && deepSleepPowerMode ##1 deepSleepPowerMode
      |=> wakeReq_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("day event did not wake the core");

  property p_keep_waking;
    @(posedge mclk) disable iff (!reset_n)
    wakeReq_q && deepSleepPowerMode && !vectorTaken
      && !$past(vectorTaken) |=> wakeReq_q;
  endproperty
  a_keep_waking: assert property (p_keep_waking)
    else $error("wake dropped before service");

  property p_hund_wrap;
    @(posedge mclk) disable iff (!porReset_n)
    tick128 && cnt_q[0] == HUND_MAX && !pendFlag_q[0] && !pendFlag_q[1]
      && cnt_q[1] != SEC_MAX |=> cnt_q[0] == 8'h00
      && cnt_q[1] == 8'($past(cnt_q[1]) + 8'h01);
  endproperty
  a_hund_wrap: assert property (p_hund_wrap)
    else $error("hundredths wrap or seconds carry wrong");

  property p_hour_limit;
    @(posedge mclk) disable iff (!porReset_n)
    rtcConfigEff_q[CFG_DAY_LENGTH_BIT] && !pendFlag_q[3] && $past(tick32_q)
      && !$past(pendFlag_q[3]) && $past(cnt_q[3]) <= HOUR24_MAX
      |-> cnt_q[3] <= HOUR24_MAX;
  endproperty
  a_hour_limit: assert property (p_hour_limit)
    else $error("hours passed 23 in 24-hour mode");

  property p_cfg_sync;
    @(posedge mclk) disable iff (!reset_n)
    tick128 |=> rtcConfigEff_q == $past(rtcConfigReg_q);
  endproperty
  a_cfg_sync: assert property (p_cfg_sync)
    else $error("config not applied at 128 Hz edge");

  c_day_event: cover property (@(posedge mclk) disable iff (!reset_n)
    dayEvent_q ##2 wakeReq_q);
  c_vector: cover property (@(posedge mclk) disable iff (!reset_n)
    rtcIrqReq_q ##[1:20] vectorTaken);
  c_key_write: cover property (@(posedge mclk) disable iff (!reset_n)
    keyWr ##[1:10] cntWrOk);

endmodule // rkmi_top

// [design/rkmi_pkg.sv]
// Shared constants, types and register map of the RTC key/mode/interrupt block
package rkmi_pkg;

  // ==========================================================================
  // Special function register addresses
  localparam logic [7:0] ADDR_CONFIG    = 8'hA1;
  localparam logic [7:0] ADDR_HUNDREDTH = 8'hA2;
  localparam logic [7:0] ADDR_SECONDS   = 8'hA3;
  localparam logic [7:0] ADDR_MINUTES   = 8'hA4;
  localparam logic [7:0] ADDR_HOURS     = 8'hA5;
  localparam logic [7:0] ADDR_INTERVAL  = 8'hA6;
  localparam logic [7:0] ADDR_IRQ_PRIO2 = 8'hA9;
  localparam logic [7:0] ADDR_KEY       = 8'hC1;
  localparam logic [7:0] ADDR_POWER     = 8'hC5;
  localparam logic [7:0] ADDR_PINCFG    = 8'hFF;

  // ==========================================================================
  // Unlock keys and reset values
  localparam logic [7:0] KEY_POWER    = 8'hA7;
  localparam logic [7:0] KEY_RTC      = 8'hEA;
  localparam logic [7:0] KEY_LOCKED   = 8'h00;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CFG_DAY_LENGTH_BIT  = 6;
  localparam int CFG_ALARM_FLAG_BIT  = 2;
  localparam int CFG_DAY_FLAG_BIT    = 1;
  localparam int PRIO2_RTC_IRQ_BIT   = 2;

  // ==========================================================================
  // Counter limits
  localparam int          NUM_COUNTERS = 4;
  localparam logic [7:0]  HUND_MAX     = 8'h7F;
  localparam logic [7:0]  SEC_MAX      = 8'h3B;
  localparam logic [7:0]  MIN_MAX      = 8'h3B;
  localparam logic [7:0]  HOUR24_MAX   = 8'h17;
  localparam logic [7:0]  HOUR256_MAX  = 8'hFF;
  localparam logic [7:0]  SUB_LAST     = 8'hFF;

  // ==========================================================================
  // Timing
  localparam int MCLK_HZ_DEFAULT = 50_000_000;
  localparam int RTC_CLK_HZ      = 32768;
  localparam int CAL_500_HZ      = 500;
  localparam int CAL_HALF_1HZ    = RTC_CLK_HZ / 2;
  localparam int CAL_HALF_512HZ  = RTC_CLK_HZ / 1024;
  localparam int CAL_HALF_16KHZ  = 1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CAL_1HZ,
    CAL_512HZ,
    CAL_500HZ,
    CAL_16KHZ
  } rkmi_calsel_e;

  typedef struct packed {
    logic       calEnable;
    logic [1:0] calFreqSelect;
    logic       reserved4;
    logic [2:0] extIrq1PinFunction;
    logic       extIrq0PinEnable;
  } rkmi_pincfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } rkmi_sfr_s;

endpackage

// [design/rkmi_cal_out.sv]
// Calibration pulse generator for the shared calibration output pin
`timescale 1ns/1ps
module rkmi_cal_out #(
  parameter int HALF_500HZ = 50000
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Control
  input  wire logic                  tick32,
  input  wire logic                  enable,
  input  wire rkmi_pkg::rkmi_calsel_e sel,
  // Output
  output logic                       calOut_q
);
  import rkmi_pkg::*;

  if (HALF_500HZ < 1 || HALF_500HZ > 65535) begin : g_chk
    $error("HALF_500HZ out of range");
  end

  logic [15:0] halfCnt_q;
  logic        step;
  logic [15:0] limit;

  // ==========================================================================
  // Half period select
  // 500 Hz does not divide 32.768 kHz, so it counts system clocks instead
  always_comb begin
    step  = (sel == CAL_500HZ) ? 1'b1 : tick32;
    case (sel)
      CAL_1HZ:   limit = 16'(CAL_HALF_1HZ - 1);
      CAL_512HZ: limit = 16'(CAL_HALF_512HZ - 1);
      CAL_500HZ: limit = 16'(HALF_500HZ - 1);
      CAL_16KHZ: limit = 16'(CAL_HALF_16KHZ - 1);
      default:   limit = 16'(CAL_HALF_1HZ - 1);
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt_q <= 16'h0000;
      calOut_q  <= 1'b0;
    end else if (!enable) begin
      halfCnt_q <= 16'h0000;
      calOut_q  <= 1'b0;
    end else if (step) begin
      if (halfCnt_q >= limit) begin
        halfCnt_q <= 16'h0000;
        calOut_q  <= ~calOut_q;
      end else begin
        halfCnt_q <= halfCnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_cal_off;
    @(posedge mclk) disable iff (!reset_n)
    !enable |=> !calOut_q;
  endproperty
  a_cal_off: assert property (p_cal_off)
    else $error("calibration output active while disabled");

  property p_cal_16k;
    @(posedge mclk) disable iff (!reset_n)
    enable && $past(enable) && sel == CAL_16KHZ && $past(sel) == CAL_16KHZ
      && tick32 |=> calOut_q != $past(calOut_q);
  endproperty
  a_cal_16k: assert property (p_cal_16k)
    else $error("16 kHz output missed a toggle");

  c_cal_toggle: cover property (@(posedge mclk) disable iff (!reset_n)
    enable ##1 $rose(calOut_q));

endmodule // rkmi_cal_out

// [sim/rkmi_core_model.sv]
// Core model that issues special function register requests
`timescale 1ns/1ps
module rkmi_core_model (
  // Clock
  input  wire logic          mclk,
  // Requests
  output rkmi_pkg::rkmi_sfr_s req
);
  import rkmi_pkg::*;
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, data: 8'h00};
  // Idle fields are inverted so a stale request never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge mclk);
    #1 req = '{wr: w, rd: ~w, addr: a, data: d};
    @(posedge mclk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic put(input logic [7:0] k, a, d);
    xfer(1'b1, ADDR_KEY, k);
    xfer(1'b1, a, d);
  endtask
endmodule // rkmi_core_model

// [sim/testbench.sv]
// Self-checking testbench of the RTC key, pin, day and interrupt block
`timescale 1ns/1ps
module testbench;
  import rkmi_pkg::*;
  logic      mclk = 1'b0, reset_n = 1'b0, porReset_n = 1'b0;
  logic      alarmEvent = 1'b0, irqVectored = 1'b0, deepSleep = 1'b0;
  rkmi_sfr_s sfrReq;
  logic [7:0] rdData, pwr, ival;
  logic      irq, wake, cal, calOe_n, g1, b1, e1, e0;
  int        n_errors = 0, check_count = 0;
  always #10 mclk = ~mclk;
  rkmi_core_model core (.mclk(mclk), .req(sfrReq));
  // Fast time base: 8 mclk per 32.768 kHz tick
  rkmi_top #(.MCLK_HZ(262144), .HALF_500HZ(10)) dut (
    .mclk(mclk), .reset_n(reset_n), .porReset_n(porReset_n),
    .sfrReq(sfrReq), .sfrRdData_q(rdData), .alarmEvent(alarmEvent),
    .irqVectored(irqVectored), .deepSleepPowerMode(deepSleep),
    .rtcIrqReq_q(irq), .wakeReq_q(wake), .calOutputPin_q(cal),
    .calOutputPinOe_n_q(calOe_n), .extIrq1GpioSel_q(g1),
    .extIrq1BattCtrlSel_q(b1), .extIrq1Enable_q(e1),
    .extIrq0Enable_q(e0), .powerControlReg_q(pwr),
    .alarmIntervalEff_q(ival));
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string w, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp, input string w);
    core.xfer(1'b0, a, 8'h00);
    check(w, rdData, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_key();
    rd(ADDR_KEY, KEY_LOCKED, "key");
    rd(8'h80, RESET_BYTE, "unmapped");
    core.xfer(1'b1, ADDR_POWER, 8'h5A);
    check("pwr nokey", pwr, 8'h00);
    core.put(KEY_RTC, ADDR_POWER, 8'h5A);
    check("pwr wrong key", pwr, 8'h00);
    core.put(KEY_POWER, ADDR_POWER, 8'h5A);
    check("pwr", pwr, 8'h5A);
    core.put(KEY_RTC, ADDR_SECONDS, 8'h1E);
    rd(ADDR_KEY, KEY_LOCKED, "relock");
    core.xfer(1'b1, ADDR_SECONDS, 8'h05);
    core.xfer(1'b1, ADDR_KEY, KEY_LOCKED);
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b0;
    @(posedge mclk);
    #1 reset_n = 1'b1;
    rd(ADDR_SECONDS, 8'h1E, "sec kept");
    core.xfer(1'b1, ADDR_INTERVAL, 8'h33);
    repeat (4096) @(posedge mclk);
    #1 check("interval", ival, 8'h33);
  endtask
  task automatic t_pins();
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {4'h0, c[2:0], c[0]};
      core.put(KEY_RTC, ADDR_PINCFG, v);
      @(posedge mclk);
      #1 check("pins", {g1, b1, e1, e0}, {c[1:0] == 2'b00,
        c[1:0] == 2'b01, c[2:1] == 2'b11, c[0]});
      rd(ADDR_PINCFG, v, "pincfg");
    end
  endtask
  task automatic t_cal();
    int lo[4] = '{0, 7, 204, 255};
    int hi[4] = '{1, 9, 205, 257};
    int n;
    logic last;
    for (int s = 0; s < 4; s++) begin
      core.put(KEY_RTC, ADDR_PINCFG, {1'b1, s[1:0], 5'h00});
      n = 0;
      for (int i = 0; i < 2048; i++) begin
        last = cal;
        @(posedge mclk);
        #1 n += (cal !== last);
      end
      check("cal rate", n >= lo[s] && n <= hi[s], 1'b1);
      check("cal oe", calOe_n, 1'b0);
    end
    core.put(KEY_RTC, ADDR_PINCFG, 8'h00);
    repeat (2) @(posedge mclk);
    #1 check("cal off", {cal, calOe_n}, 2'b01);
  endtask
  task automatic t_day();
    int i;
    core.xfer(1'b1, ADDR_CONFIG, 8'h40);
    repeat (4096) @(posedge mclk);
    #1 deepSleep = 1'b1;
    core.put(KEY_RTC, ADDR_HOURS, HOUR24_MAX);
    core.put(KEY_RTC, ADDR_MINUTES, MIN_MAX);
    core.put(KEY_RTC, ADDR_SECONDS, SEC_MAX);
    core.put(KEY_RTC, ADDR_HUNDREDTH, HUND_MAX);
    check("early wake", wake, 1'b0);
    for (i = 0; i < 3000 && wake !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 3000) begin
      n_errors++;
      complete_run();
    end
    check("gated", irq, 1'b0);
    rd(ADDR_CONFIG, 8'h42, "day flag");
    rd(ADDR_HOURS, 8'h00, "hours");
    pulse(irqVectored);
    check("still wake", wake, 1'b1);
    core.xfer(1'b1, ADDR_IRQ_PRIO2, 8'h04);
    repeat (2) @(posedge mclk);
    #1 check("irq", irq, 1'b1);
    pulse(irqVectored);
    check("serviced", {irq, wake}, 2'b00);
    rd(ADDR_CONFIG, 8'h42, "flag held");
    pulse(alarmEvent);
    check("alarm irq", irq, 1'b1);
    rd(ADDR_CONFIG, 8'h46, "alarm flag");
  endtask
  // Hour 23 in 256-hour mode is no day event; hundredths wrap carries seconds
  task automatic t_roll();
    core.xfer(1'b1, ADDR_CONFIG, 8'h00);
    rd(ADDR_CONFIG, 8'h00, "flags cleared");
    repeat (2100) @(posedge mclk);
    core.put(KEY_RTC, ADDR_HOURS, HOUR24_MAX);
    core.put(KEY_RTC, ADDR_MINUTES, MIN_MAX);
    core.put(KEY_RTC, ADDR_SECONDS, SEC_MAX);
    core.put(KEY_RTC, ADDR_HUNDREDTH, HUND_MAX);
    repeat (2100) @(posedge mclk);
    rd(ADDR_HOURS, 8'h18, "256h hours");
    rd(ADDR_CONFIG, 8'h00, "no day event");
    core.put(KEY_RTC, ADDR_HUNDREDTH, HUND_MAX);
    repeat (2100) @(posedge mclk);
    rd(ADDR_SECONDS, 8'h01, "sec carry");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    porReset_n = 1'b1;
    check("oe reset", calOe_n, 1'b1);
    t_key();
    t_pins();
    t_cal();
    t_day();
    t_roll();
    complete_run();
  end
endmodule // testbench
